// file: rtl/tmg_pkg.sv
// Constants shared by the timer event request and output guard block.
// Assumes a single clock domain; the register port is a plain strobe port.
package tmg_pkg;
  localparam int          NCH          = 5;
  localparam int          NMATCH       = 4;
  localparam int          NDTC         = 17;
  localparam int          NSTOP        = 4;
  localparam int          NPWM         = 6;
  // Bit positions inside the flag and enable registers
  localparam int          OVF_BIT      = 4;
  localparam int          UNF_BIT      = 5;
  localparam int          ADC_EN_BIT   = 7;
  // Register byte offsets
  localparam logic [7:0]  FLAG_BASE    = 8'h00;
  localparam logic [7:0]  EN_BASE      = 8'h20;
  localparam logic [7:0]  BCR_OFS      = 8'h40;
  localparam logic [7:0]  GSTAT_OFS    = 8'h44;
  localparam logic [7:0]  GMASK_OFS    = 8'h48;
  localparam int          BCR_PROT_BIT = 13;
  localparam logic        BCR_RST      = 1'b1;
  // Implemented match sources and underflow per channel, and write-protected enables
  localparam logic [NCH*NMATCH-1:0] CH_MATCH = 20'hFF33F;
  localparam logic [NCH-1:0]        CH_UNF   = 5'h06;
  localparam logic [NCH-1:0]        CH_PROT  = 5'h18;
  // Source codes in fixed priority order
  localparam logic [2:0]  SRC_OVF      = 3'h4;
  localparam logic [2:0]  SRC_UNF      = 3'h5;
  localparam logic [2:0]  SRC_NONE     = 3'h7;
  typedef enum logic [1:0] {
    TMG_RUN  = 2'h1,
    TMG_HALT = 2'h2
  } tmg_guard_t;
endpackage

// file: rtl/tmg_sync.sv
// Two flip-flop synchroniser for pin level inputs.
// Assumes the inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ps
module tmg_sync
  import tmg_pkg::*;
#(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tmg_sync_t;
  tmg_sync_t st;
  tmg_sync_t next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  // Idle level at reset so a held pin does not trip a false stop
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st <= '{s1: RST, s2: RST};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;
endmodule // tmg_sync

// file: rtl/tmg_chan.sv
// One timer channel: event flags, request enables and request lines.
// Assumes event inputs are one-cycle pulses from the counter logic on clk_in.
`timescale 1ns/1ps
module tmg_chan
  import tmg_pkg::*;
#(
  parameter logic [3:0] MATCH_MASK = 4'hF,
  parameter logic       HAS_UNF    = 1'b0
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [3:0] match_evt_in,
  input  wire logic       ovf_evt_in,
  input  wire logic       unf_evt_in,
  input  wire logic       en_we_in,
  input  wire logic       clr_we_in,
  input  wire logic [7:0] wr_data_in,
  output logic      [7:0] flag_out,
  output logic      [7:0] enable_out,
  output logic      [5:0] req_out,
  output logic      [2:0] top_src_out,
  output logic            adc_start_out
);
  localparam logic [7:0] IMPL = {2'h0, HAS_UNF, 1'b1, MATCH_MASK};
  typedef struct packed {
    logic [7:0] flag;
    logic [7:0] enable;
    logic [5:0] req;
    logic [2:0] top;
    logic       adc;
  } tmg_chan_t;
  tmg_chan_t st;
  tmg_chan_t next_st;

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    logic [7:0] evt;
    evt = {2'h0, unf_evt_in, ovf_evt_in, match_evt_in} & IMPL;
    next_st = st;
    next_st.flag = ((st.flag & ~(clr_we_in ? wr_data_in : 8'h00)) | evt) & IMPL;
    if (en_we_in) begin
      next_st.enable = wr_data_in & (IMPL | 8'h80);
    end
    // Request follows flag and enable, so a late enable raises it at once
    next_st.req = next_st.flag[5:0] & next_st.enable[5:0];
    next_st.adc = evt[0] & st.enable[ADC_EN_BIT];
    // Lowest index wins: match A first, underflow last
    next_st.top = SRC_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (next_st.req[i]) begin
        next_st.top = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st <= '{flag: 8'h00, enable: 8'h00, req: 6'h00, top: SRC_NONE, adc: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign flag_out      = st.flag;
  assign enable_out    = st.enable;
  assign req_out       = st.req;
  assign top_src_out   = st.top;
  assign adc_start_out = st.adc;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  ovf_flag_set_a: assert property (ovf_evt_in |=> flag_out[OVF_BIT]) else $error("overflow flag not set");
  unf_flag_set_a: assert property ((unf_evt_in && HAS_UNF) |=> flag_out[UNF_BIT])
    else $error("underflow flag not set");
  flag_hold_a: assert property ((flag_out[OVF_BIT] && !(clr_we_in && wr_data_in[OVF_BIT])) |=> flag_out[OVF_BIT])
    else $error("flag dropped without clear");
  req_gate_a: assert property (req_out[OVF_BIT] |-> (flag_out[OVF_BIT] && enable_out[OVF_BIT]))
    else $error("request without flag and enable");
  late_enable_a: assert property ((flag_out[OVF_BIT] && !clr_we_in && en_we_in && wr_data_in[OVF_BIT])
    |=> req_out[OVF_BIT]) else $error("late enable did not raise request");
  adc_start_a: assert property ((match_evt_in[0] && enable_out[ADC_EN_BIT]) |=> adc_start_out)
    else $error("conversion start missing");
  prio_fixed_a: assert property (req_out[0] |-> (top_src_out == 3'h0)) else $error("match A not on top");
endmodule // tmg_chan

// file: rtl/tmg_top.sv
// Top of the timer event request and output guard block: register port,
// write protection, per-channel request aggregation and PWM output stop.
// Assumes events and PWM levels arrive on clk_in; stop pins and the
// oscillator-stop level come from outside and are synchronised here.
`timescale 1ns/1ps
module tmg_top
  import tmg_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  input  wire logic [7:0]            addr_in,
  input  wire logic [31:0]           wr_data_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [31:0]           rd_data_out,
  input  wire logic [NCH*NMATCH-1:0] match_evt_in,
  input  wire logic [NCH-1:0]        ovf_evt_in,
  input  wire logic [NCH-1:0]        unf_evt_in,
  input  wire logic [NSTOP-1:0]      stop_n_in,
  input  wire logic                  osc_stop_in,
  input  wire logic [NPWM-1:0]       pwm_in,
  output logic      [NPWM-1:0]       pwm_out,
  output logic      [NPWM-1:0]       pwm_oe_n_out,
  output logic      [NCH-1:0]        ch_req_out,
  output logic      [NCH*3-1:0]      ch_top_src_out,
  output logic      [NDTC-1:0]       dtc_req_out,
  output logic      [NCH-1:0]        adc_start_out,
  output logic                       irq_out
);
  typedef struct packed {
    logic [31:0]     rdata;
    logic            access_en;
    logic [1:0]      gstat;
    logic [1:0]      gmask;
    tmg_guard_t      gstate;
    logic [NPWM-1:0] pwm;
    logic [NPWM-1:0] oe_n;
    logic [NCH-1:0]  ch_req;
    logic            irq;
  } tmg_top_t;
  tmg_top_t st;
  tmg_top_t next_st;

  logic [7:0]       ch_flag   [NCH];
  logic [7:0]       ch_enable [NCH];
  logic [5:0]       ch_req    [NCH];
  logic [NCH-1:0]   en_we;
  logic [NCH-1:0]   clr_we;
  logic [NSTOP-1:0] stop_n_s;
  logic             osc_stop_s;
  logic             wr_ok;
  logic             stop_cond;

  // Enable-register offset of a channel
  function automatic logic [7:0] en_addr(input int c);
    en_addr = 8'(EN_BASE + 8'(4 * c));
  endfunction

  // Write-protected offsets owned by this block: channel 3 and 4 enables.
  // The flag registers are left out, so they stay writable at all times.
  function automatic logic is_guarded(input logic [7:0] a);
    is_guarded = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (CH_PROT[c] && (a == en_addr(c))) begin
        is_guarded = 1'b1;
      end
    end
  endfunction

  // Stop pins are active low and idle high
  tmg_sync #(
    .W   (NSTOP),
    .RST ({NSTOP{1'b1}})
  ) u_stop_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (stop_n_in),
    .sync_out (stop_n_s)
  );

  // A dead clock cannot clock this stage; the detector is expected to
  // hold its level until the clock is back, and nothing is promised then
  tmg_sync #(
    .W   (1),
    .RST (1'b0)
  ) u_osc_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (osc_stop_in),
    .sync_out (osc_stop_s)
  );

  // Write gating: protected enables ignore writes while access is off
  assign wr_ok     = wr_in && !(is_guarded(addr_in) && !st.access_en);
  assign stop_cond = !(&stop_n_s) || osc_stop_s;

  // One channel instance per timer channel
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      assign en_we[c]  = wr_ok && (addr_in == en_addr(c));
      assign clr_we[c] = wr_in && (addr_in == 8'(FLAG_BASE + 8'(4 * c)));
      tmg_chan #(
        .MATCH_MASK (CH_MATCH[c*NMATCH +: NMATCH]),
        .HAS_UNF    (CH_UNF[c])
      ) u_chan (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .match_evt_in  (match_evt_in[c*NMATCH +: NMATCH]),
        .ovf_evt_in    (ovf_evt_in[c]),
        .unf_evt_in    (unf_evt_in[c]),
        .en_we_in      (en_we[c]),
        .clr_we_in     (clr_we[c]),
        .wr_data_in    (wr_data_in[7:0]),
        .flag_out      (ch_flag[c]),
        .enable_out    (ch_enable[c]),
        .req_out       (ch_req[c]),
        .top_src_out   (ch_top_src_out[c*3 +: 3]),
        .adc_start_out (adc_start_out[c])
      );
    end
  endgenerate

  // Transfer triggers: channel 4 adds its overflow as fifth source
  assign dtc_req_out = {ch_req[4][OVF_BIT], ch_req[4][3:0], ch_req[3][3:0],
                        ch_req[2][1:0], ch_req[1][1:0], ch_req[0][3:0]};

  // Register port, guard state machine and interrupt output
  always_comb begin
    logic [31:0] rd;
    logic        halt_set;
    logic        blk_set;
    logic [1:0]  gclr;
    rd       = 32'h0000_0000;
    halt_set = 1'b0;
    blk_set  = 1'b0;
    gclr     = 2'h0;
    next_st  = st;
    // Read data appear in the cycle after the strobe; unmapped reads give 0
    if (rd_in) begin
      for (int c = 0; c < NCH; c++) begin
        if (addr_in == 8'(FLAG_BASE + 8'(4 * c))) begin
          rd = {24'h00_0000, ch_flag[c]};
        end
        if (addr_in == en_addr(c)) begin
          rd = {24'h00_0000, ch_enable[c]};
        end
      end
      case (addr_in)
        BCR_OFS: begin
          rd[BCR_PROT_BIT] = st.access_en;
        end
        GSTAT_OFS: begin
          rd = {19'h0_0000, osc_stop_s, stop_n_s, 6'h00, st.gstat};
        end
        GMASK_OFS: begin
          rd = {30'h0000_0000, st.gmask};
        end
        default: begin
          rd = rd;
        end
      endcase
    end
    next_st.rdata = rd;
    // Control writes; the protection bit itself is never guarded
    if (wr_in) begin
      case (addr_in)
        BCR_OFS: begin
          next_st.access_en = wr_data_in[BCR_PROT_BIT];
        end
        GSTAT_OFS: begin
          gclr = wr_data_in[1:0];
        end
        GMASK_OFS: begin
          next_st.gmask = wr_data_in[1:0];
        end
        default: begin
          next_st.gmask = st.gmask;
        end
      endcase
    end
    blk_set = wr_in && !wr_ok;
    // Halt latch: stays set while the stop condition persists
    halt_set = stop_cond;
    next_st.gstat = (st.gstat & ~gclr) | {blk_set, halt_set};
    case (st.gstate)
      TMG_RUN: begin
        if (stop_cond) begin
          next_st.gstate = TMG_HALT;
        end
      end
      TMG_HALT: begin
        // Resume only once software has cleared the latch
        if (!next_st.gstat[0]) begin
          next_st.gstate = TMG_RUN;
        end
      end
      default: begin
        next_st.gstate = TMG_HALT;
      end
    endcase
    next_st.pwm  = pwm_in;
    next_st.oe_n = (next_st.gstate == TMG_RUN) ? {NPWM{1'b0}} : {NPWM{1'b1}};
    for (int c = 0; c < NCH; c++) begin
      next_st.ch_req[c] = |ch_req[c];
    end
    next_st.irq = (|next_st.ch_req) || (|(next_st.gstat & st.gmask));
  end

  // Outputs at reset: PWM driven, no requests
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st <= '{rdata: 32'h0000_0000, access_en: BCR_RST, gstat: 2'h0, gmask: 2'h0,
              gstate: TMG_RUN, pwm: {NPWM{1'b0}}, oe_n: {NPWM{1'b0}},
              ch_req: {NCH{1'b0}}, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_out  = st.rdata;
  assign pwm_out      = st.pwm;
  assign pwm_oe_n_out = st.oe_n;
  assign ch_req_out   = st.ch_req;
  assign irq_out      = st.irq;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence stop_pin_held_s;
    !stop_n_in[0] [*3];
  endsequence
  sequence osc_halt_held_s;
    osc_stop_in [*3];
  endsequence

  guard_write_a: assert property ((wr_in && !st.access_en && (addr_in == en_addr(3)))
    |=> (ch_enable[3] == $past(ch_enable[3]))) else $error("protected write took effect");
  free_flag_a: assert property ((wr_in && !st.access_en && (addr_in == 8'(FLAG_BASE + 8'h0C))
    && wr_data_in[OVF_BIT] && !ovf_evt_in[3]) |=> !ch_flag[3][OVF_BIT]) else $error("flag clear blocked");
  stop_pin_a: assert property (stop_pin_held_s |-> ##[1:2] (pwm_oe_n_out == 6'h3F))
    else $error("PWM not released on stop pin");
  osc_halt_a: assert property (osc_halt_held_s |-> ##[1:2] (pwm_oe_n_out == 6'h3F))
    else $error("PWM not released on clock stop");
  chan_req_a: assert property ((|ch_req[2]) |=> ch_req_out[2]) else $error("channel request lost");
  dtc_map_a: assert property (ch_req[4][OVF_BIT] |-> dtc_req_out[16]) else $error("fifth trigger missing");
  irq_out_a: assert property ((|ch_req[0]) |=> irq_out) else $error("interrupt output low");
endmodule // tmg_top

// file: dv/tmg_far_model.sv
// Far-side model: the converter that takes timer conversion start pulses.
// Assumes start pulses are one clk_in cycle wide and the trigger choice is a level.
`timescale 1ns/1ps
module tmg_far_model
  import tmg_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           reset_in,
  input  wire logic [NCH-1:0] start_in,
  input  wire logic           trig_sel_in,
  output int                  conv_count_out
);
  // A start only counts while the timer is the chosen trigger, as the real converter ignores the rest
  always @(posedge clk_in) begin
    if (reset_in) begin
      conv_count_out <= 0;
    end else if (trig_sel_in) begin
      conv_count_out <= conv_count_out + $countones(start_in);
    end
  end
endmodule // tmg_far_model

// file: dv/timer_event_request_and_output_guard_tb.sv
// Self-checking bench for the timer event request and output guard block.
// Assumes tmg_pkg, tmg_top and tmg_far_model are compiled before this file.
`timescale 1ns/1ps
module timer_event_request_and_output_guard_tb;
  import tmg_pkg::*;
  logic                  clk_in = 0, reset_in = 1, wr_in = 0, rd_in = 0, osc_stop_in = 0, trig_sel = 0;
  logic [7:0]            addr_in = '0;
  logic [31:0]           wr_data_in = '0, rd_data_out;
  logic [NCH*NMATCH-1:0] match_evt_in = '0;
  logic [NCH-1:0]        ovf_evt_in = '0, unf_evt_in = '0, ch_req_out, adc_start_out, exp_adc;
  logic [NSTOP-1:0]      stop_n_in = '1;
  logic [NPWM-1:0]       pwm_in = '0, pwm_out, pwm_oe_n_out;
  logic [NCH*3-1:0]      ch_top_src_out;
  logic [NDTC-1:0]       dtc_req_out;
  logic                  irq_out;
  int                    failures, comparisons, conv_count, exp_conv, seed, n, m;
  int                    flag[NCH], en[NCH];
  // Clock at 25 MHz
  always #20 clk_in = ~clk_in;
  tmg_top i_tmg_top (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .match_evt_in(match_evt_in),
    .ovf_evt_in(ovf_evt_in), .unf_evt_in(unf_evt_in), .stop_n_in(stop_n_in), .osc_stop_in(osc_stop_in),
    .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_oe_n_out(pwm_oe_n_out), .ch_req_out(ch_req_out),
    .ch_top_src_out(ch_top_src_out), .dtc_req_out(dtc_req_out), .adc_start_out(adc_start_out),
    .irq_out(irq_out));
  tmg_far_model i_tmg_far_model (.clk_in(clk_in), .reset_in(reset_in), .start_in(adc_start_out),
    .trig_sel_in(trig_sel), .conv_count_out(conv_count));
  // Compare and count; four-state compare so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One-cycle write strobe, released one edge later
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in      <= 1'b1;
    addr_in    <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in      <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 chk(rd_data_out, exp, what);
  endtask
  // Transfer trigger lines expected from the model flags and enables
  function automatic logic [31:0] exp_dtc();
    logic [31:0] v;
    int          p[NCH] = '{0, 4, 6, 8, 12};
    v = '0;
    for (int c = 0; c < NCH; c++)
      for (int b = 0; b < 4; b++)
        if (CH_MATCH[4*c+b] && flag[c][b] && en[c][b]) v[p[c]+b] = 1'b1;
    v[16] = flag[4][OVF_BIT] & en[4][OVF_BIT];
    return v;
  endfunction
  function automatic logic [31:0] exp_req();
    logic [31:0] v;
    v = '0;
    for (int c = 0; c < NCH; c++) v[c] = ((flag[c] & en[c] & 32'h3F) != 0);
    return v;
  endfunction
  // Bits a channel really keeps in its enable register, converter trigger enable included
  function automatic int impl(input int c);
    return {CH_UNF[c], 1'b1, CH_MATCH[4*c +: 4]} | 32'h80;
  endfunction
  // Highest pending source per channel, lowest index first, none when idle
  function automatic logic [31:0] exp_top();
    logic [31:0] v;
    v = '0;
    for (int c = 0; c < NCH; c++) begin
      v[3*c +: 3] = SRC_NONE;
      for (int i = 5; i >= 0; i--) if (flag[c][i] && en[c][i]) v[3*c +: 3] = 3'(i);
    end
    return v;
  endfunction
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog: a hang counts as a failure
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    summarize();
  end
  initial begin
    seed = $urandom(32'hEDCC66CB);
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(BCR_OFS, 32'h2000, "access enable after reset");
    rd(FLAG_BASE, 32'h0, "flags after reset");
    chk(irq_out, 1'b0, "irq after reset");
    $display("test reset done");
    // Random enables and events; stale flags must raise a request once enabled
    for (int it = 0; it < 20; it++) begin
      trig_sel <= it[0];
      for (int c = 0; c < NCH; c++) begin
        m = $urandom;
        en[c] = m & impl(c);
        wr(EN_BASE + 8'(4*c), m);
      end
      @(posedge clk_in);
      match_evt_in <= $urandom;
      ovf_evt_in   <= $urandom;
      unf_evt_in   <= $urandom;
      pwm_in       <= $urandom;
      @(posedge clk_in);
      for (int c = 0; c < NCH; c++) begin
        exp_adc[c] = match_evt_in[4*c] & en[c][ADC_EN_BIT];
        for (int b = 0; b < 4; b++) if (CH_MATCH[4*c+b] && match_evt_in[4*c+b]) flag[c][b] = 1'b1;
        if (ovf_evt_in[c]) flag[c][OVF_BIT] = 1'b1;
        if (CH_UNF[c] && unf_evt_in[c]) flag[c][UNF_BIT] = 1'b1;
      end
      if (trig_sel) exp_conv += $countones(exp_adc);
      match_evt_in <= '0;
      ovf_evt_in   <= '0;
      unf_evt_in   <= '0;
      #1 chk(adc_start_out, exp_adc, "converter start");
      chk(dtc_req_out, exp_dtc(), "transfer triggers");
      chk(ch_top_src_out, exp_top(), "source order");
      chk(pwm_out, pwm_in, "PWM pass-through");
      @(posedge clk_in);
      #1 chk(ch_req_out, exp_req(), "channel requests");
      chk(irq_out, |exp_req(), "irq level");
      for (int c = 0; c < NCH; c++) rd(FLAG_BASE + 8'(4*c), flag[c], "flag register");
      for (int c = 0; c < NCH; c++) begin
        m = $urandom & 32'h3F;
        wr(FLAG_BASE + 8'(4*c), m);
        flag[c] &= ~m;
      end
      for (int c = 0; c < NCH; c++) rd(FLAG_BASE + 8'(4*c), flag[c], "flag after clear");
    end
    repeat (2) @(posedge clk_in);
    chk(conv_count, exp_conv, "conversions started");
    for (int c = 0; c < NCH; c++) begin
      wr(FLAG_BASE + 8'(4*c), 32'h3F);
      flag[c] = 0;
    end
    $display("test events done");
    // Blocked write to a protected enable register, then its interrupt masked in and cleared
    wr(BCR_OFS, 32'h0);
    wr(EN_BASE + 8'h10, 32'h10);
    rd(EN_BASE + 8'h10, en[4], "protected register kept");
    wr(EN_BASE + 8'h0C, 32'h9F);
    rd(EN_BASE + 8'h0C, en[3], "channel 3 enable kept");
    wr(EN_BASE, 32'h01);
    rd(EN_BASE, 32'h01, "unprotected enable written");
    en[0] = 32'h01;
    // Flag registers stand outside the protected set, so a clear still lands
    @(posedge clk_in);
    ovf_evt_in <= 5'h08;
    @(posedge clk_in);
    ovf_evt_in <= '0;
    wr(FLAG_BASE + 8'h0C, 32'h10);
    rd(FLAG_BASE + 8'h0C, 32'h0, "flag clear while protected");
    rd(GSTAT_OFS, 32'hF02, "blocked write status");
    wr(GMASK_OFS, 32'h2);
    repeat (2) @(posedge clk_in);
    #1 chk(irq_out, 1'b1, "irq from blocked write");
    wr(GSTAT_OFS, 32'h2);
    repeat (2) @(posedge clk_in);
    #1 chk(irq_out, 1'b0, "irq after clear");
    wr(BCR_OFS, 32'h2000);
    $display("test protection done");
    // Each stop pin and the oscillator stop must float all six outputs
    for (int k = 0; k <= NSTOP; k++) begin
      @(posedge clk_in);
      if (k < NSTOP) stop_n_in[k] <= 1'b0;
      else osc_stop_in <= 1'b1;
      n = 0;
      while (pwm_oe_n_out !== 6'h3F && n < 8) begin
        @(posedge clk_in);
        #1 n++;
      end
      chk(n, 3, "halt latency");
      if (n == 8) summarize();
      @(posedge clk_in);
      stop_n_in   <= '1;
      osc_stop_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      wr(GSTAT_OFS, 32'h1);
      #1 chk(pwm_oe_n_out, 6'h00, "outputs driven again");
    end
    $display("test guard done");
    // Mid-run reset with flags pending must bring every request back to idle
    @(posedge clk_in);
    ovf_evt_in <= '1;
    @(posedge clk_in);
    ovf_evt_in <= '0;
    reset_in   <= 1'b1;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    #1 chk(ch_top_src_out, {NCH{SRC_NONE}}, "codes after reset");
    chk(dtc_req_out, 0, "triggers after reset");
    chk(pwm_oe_n_out, 0, "outputs driven after reset");
    rd(FLAG_BASE + 8'h10, 32'h0, "flag after reset");
    rd(EN_BASE, 32'h0, "enable after reset");
    chk(irq_out, 1'b0, "irq after mid-run reset");
    $display("test mid-run reset done");
    summarize();
  end
endmodule // timer_event_request_and_output_guard_tb
